/* rtl/tmr_timer8.sv */
// How it works
// [R1] Counting sequence follows waveform mode only; output action affects pins.
// [R2] Normal mode counts up always, wrapping 0xFF to 0x00.
// [R3] Normal mode sets overflow flag as count becomes zero; only set.
// [R4] Normal mode accepts a CPU count write at any moment.
// [R5] Clear-on-match mode clears count on compare A match; A is TOP.
// [R6] Clear-on-match compare A is direct; low writes run to 0xFF first.
// [R7] Clear-on-match with action 1 toggles channel A output per match.
// [R8] Clear-on-match sets overflow flag when count passes MAX to zero.
// [R9] Fast PWM counts BOTTOM to TOP; TOP is 0xFF or compare A.
// [R10] Fast PWM clears the count on the tick after count equals TOP.
// [R11] Fast PWM action 2 clears on match, sets at BOTTOM; 3 inverts.
// [R12] Fast PWM sets overflow flag each time count reaches TOP.
// [R13] Fast PWM compare BOTTOM gives spike; MAX gives constant level.
// [R14] Fast PWM action 1 toggles per match; compare stays double buffered.
// [R15] Phase correct counts up to TOP then down to BOTTOM repeatedly.
// [R16] Phase correct holds TOP one tick, then reverses direction.
// [R17] Phase correct action 2 clears on up match, sets down; 3 inverts.
// [R18] Phase correct sets overflow flag each time count reaches BOTTOM.
// [R19] Compare output drives its pin only while pin direction is output.
// [R20] Timer tick is ref clock divided by 1,8,32,64,128,256 or 1024.
// [R21] Action zero leaves the internal compare output untouched on match.
// [R22] Compare flag sets one tick after match; write one clears it.
// [R23] Prescale zero stops the timer; count stays readable and writable.
// [R24] Interrupt request while any set flag has its enable set.
module tmr_timer8 (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [1:0]       cmp_out,
  output logic [1:0]       cmp_out_oe,
  output logic             irq
);

  tmr_pkg::tmr_ctrl_t ctrl_r;
  logic [7:0]         cnt_r;
  logic [7:0]         cnt_nxt;
  logic               down_r;
  logic               down_nxt;
  logic               blk_r;
  logic [9:0]         div_r;
  logic [2:0]         flag_r;
  logic [2:0]         flag_nxt;
  logic [2:0]         irq_en_r;
  logic [31:0]        prdata_r;
  logic [7:0]         buf_r   [2];
  logic [7:0]         act_r   [2];
  logic [1:0]         oc_r;
  logic [1:0]         hit;
  logic [1:0]         force_st;
  logic [1:0]         cmp_wr;

  // Bus decode
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire hit_ctl = paddr == tmr_pkg::ADDR_CTRL;
  wire hit_cnt = paddr == tmr_pkg::ADDR_COUNT;
  wire hit_ca  = paddr == tmr_pkg::ADDR_CMPA;
  wire hit_cb  = paddr == tmr_pkg::ADDR_CMPB;
  wire hit_flg = paddr == tmr_pkg::ADDR_FLAGS;
  wire hit_ien = paddr == tmr_pkg::ADDR_IRQEN;
  wire mapped  = hit_ctl | hit_cnt | hit_ca | hit_cb | hit_flg | hit_ien;
  wire wr      = access & pwrite & mapped;
  wire ctl_wr  = wr & hit_ctl;
  wire cnt_wr  = wr & hit_cnt;
  wire flg_wr  = wr & hit_flg;
  wire ien_wr  = wr & hit_ien;

  assign cmp_wr[0] = wr & hit_ca;
  assign cmp_wr[1] = wr & hit_cb;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_r;

  // Read sources, zero-extended to the bus width
  wire [31:0] rd_ctl = {20'h0_0000, ctrl_r};
  wire [31:0] rd_cnt = {24'h00_0000, cnt_r};
  wire [31:0] rd_ca  = {24'h00_0000, buf_r[0]};
  wire [31:0] rd_cb  = {24'h00_0000, buf_r[1]};
  wire [31:0] rd_flg = {29'h000_0000, flag_r};
  wire [31:0] rd_ien = {29'h000_0000, irq_en_r};

  // Unmapped reads return zero so a stray access leaks nothing
  wire [31:0] rd_mux =
    hit_ctl ? rd_ctl :
    hit_cnt ? rd_cnt :
    hit_ca  ? rd_ca  :
    hit_cb  ? rd_cb  :
    hit_flg ? rd_flg :
    hit_ien ? rd_ien :
              32'h0000_0000;

  // Mode classes
  // [R1] Mode alone
  wire is_fast = ctrl_r.mode == tmr_pkg::TMR_FAST_FF |
                 ctrl_r.mode == tmr_pkg::TMR_FAST_OCR;
  wire is_pc   = ctrl_r.mode == tmr_pkg::TMR_PC_FF |
                 ctrl_r.mode == tmr_pkg::TMR_PC_OCR;
  wire is_ctc  = ctrl_r.mode == tmr_pkg::TMR_CTC;
  wire is_pwm  = is_fast | is_pc;
  wire top_ocr = ctrl_r.mode == tmr_pkg::TMR_FAST_OCR |
                 ctrl_r.mode == tmr_pkg::TMR_PC_OCR;

  // [R9] TOP selection
  wire [7:0] top_val = top_ocr ? act_r[0] : tmr_pkg::CNT_MAX;

  // Prescaler: shared free divider keeps the phase between selections
  // [R20] Divide select
  wire [9:0] div_mask =
    ctrl_r.presc == 3'd1 ? tmr_pkg::DIV_1    :
    ctrl_r.presc == 3'd2 ? tmr_pkg::DIV_8    :
    ctrl_r.presc == 3'd3 ? tmr_pkg::DIV_32   :
    ctrl_r.presc == 3'd4 ? tmr_pkg::DIV_64   :
    ctrl_r.presc == 3'd5 ? tmr_pkg::DIV_128  :
    ctrl_r.presc == 3'd6 ? tmr_pkg::DIV_256  :
                           tmr_pkg::DIV_1024;
  // First tick after a new selection may come early: the divider is shared
  wire div_hit = (div_r & div_mask) == div_mask;
  // [R23] Stopped timer
  wire run_en  = ctrl_r.presc != 3'd0;
  wire tick    = run_en & div_hit;

  // Counter sequencing
  wire at_top  = cnt_r == top_val;
  wire at_bot  = cnt_r == tmr_pkg::CNT_BOT;
  wire at_max  = cnt_r == tmr_pkg::CNT_MAX;
  wire [7:0] cnt_inc = cnt_r + 8'h01;
  wire [7:0] cnt_dec = cnt_r - 8'h01;
  wire match_a = (cnt_r == act_r[0]) & ~blk_r;

  // [R16] Hold TOP one tick, reverse
  wire pc_rev_dn = ~down_r & (cnt_r >= top_val);
  wire pc_rev_up = down_r & at_bot;
  // [R15] Dual slope
  wire [7:0] pc_next =
    (down_r & ~pc_rev_up) | pc_rev_dn ? cnt_dec : cnt_inc;

  // [R5] Clear on match
  wire ctc_clr  = is_ctc & match_a;
  // [R10] Clear after TOP
  wire fast_clr = is_fast & at_top;

  // [R2] Normal wrap
  wire [7:0] cnt_run =
    is_pc                ? pc_next           :
    (ctc_clr | fast_clr) ? tmr_pkg::CNT_BOT  :
                           cnt_inc;

  // [R4] CPU write has priority
  assign cnt_nxt = cnt_wr ? pwdata[7:0] :
                   tick   ? cnt_run     :
                            cnt_r;

  assign down_nxt = ~is_pc ? 1'b0                 :
                    ~tick  ? down_r               :
                    down_r ? ~pc_rev_up : pc_rev_dn;

  // Overflow event
  // [R3] Normal wrap
  // [R8] Clear-on-match wrap
  // [R12] Fast TOP
  // [R18] Phase correct BOTTOM
  wire ovf_fast = is_fast & at_top;
  wire ovf_pc   = is_pc & down_r & at_bot;
  wire ovf_wrap = ~is_pwm & at_max;
  wire ovf_ev   = tick & (ovf_fast | ovf_pc | ovf_wrap);

  // Double buffer reload point: BOTTOM for fast, TOP for phase correct
  // [R14] Buffered compare
  wire reload = tick & ((is_fast & at_top) | (is_pc & pc_rev_dn));

  // Fast PWM restart at BOTTOM
  wire fast_bot = tick & is_fast & at_top;

  // Phase correct match direction; extremes pinned for symmetry
  wire pc_up = at_bot ? 1'b1 : at_top ? 1'b0 : ~down_r;

  // [R22] Set wins over write-one clear
  assign flag_nxt =
    (flag_r & ~({3{flg_wr}} & pwdata[2:0])) |
    {tick & hit[1], tick & hit[0], ovf_ev};

  assign force_st[0] = ctl_wr & pwdata[tmr_pkg::FORCE_A_BIT] & ~is_pwm;
  assign force_st[1] = ctl_wr & pwdata[tmr_pkg::FORCE_B_BIT] & ~is_pwm;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      tmr_pkg::tmr_act_t act;
      logic [7:0]        buf_nxt;
      logic              oc_nxt;

      assign act = (g == 0) ? ctrl_r.act_a : ctrl_r.act_b;
      assign hit[g] = (cnt_r == act_r[g]) & ~blk_r;
      assign buf_nxt = cmp_wr[g] ? pwdata[7:0] : buf_r[g];

      // Software always sees the buffer, never the active compare
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          buf_r[g] <= tmr_pkg::CMP_RST;
        end else begin
          buf_r[g] <= buf_nxt;
        end
      end

      // [R6] Direct in non-PWM
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          act_r[g] <= tmr_pkg::CMP_RST;
        end else if (!is_pwm || reload) begin
          act_r[g] <= buf_nxt;
        end
      end

      // Fast PWM restart level at BOTTOM per polarity
      wire bot_hi = fast_bot & (act == tmr_pkg::TMR_ACT_CLEAR);
      wire bot_lo = fast_bot & (act == tmr_pkg::TMR_ACT_SET);

      always_comb begin
        oc_nxt = oc_r[g];
        if (force_st[g] || (tick && hit[g])) begin
          case (act)
            // [R21] No action
            tmr_pkg::TMR_ACT_NONE: oc_nxt = oc_r[g];
            // [R7] Toggle
            // [R14] Toggle in fast
            tmr_pkg::TMR_ACT_TOGGLE: begin
              if (!is_pc) begin
                oc_nxt = ~oc_r[g];
              end
            end
            // [R17] Up clears, down sets
            tmr_pkg::TMR_ACT_CLEAR: begin
              if (is_pc) begin
                oc_nxt = ~pc_up;
              end else begin
                oc_nxt = 1'b0;
              end
            end
            tmr_pkg::TMR_ACT_SET: begin
              if (is_pc) begin
                oc_nxt = pc_up;
              end else begin
                oc_nxt = 1'b1;
              end
            end
            default: oc_nxt = oc_r[g];
          endcase
        end
        // BOTTOM wins over a same-tick match so MAX holds steady
        // [R11] Set or clear at BOTTOM
        // [R13] Extreme values
        if (bot_hi) begin
          oc_nxt = 1'b1;
        end
        if (bot_lo) begin
          oc_nxt = 1'b0;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          oc_r[g] <= 1'b0;
        end else begin
          oc_r[g] <= oc_nxt;
        end
      end
    end
  endgenerate

  // [R19] Pin driven only as output
  assign cmp_out    = oc_r;
  assign cmp_out_oe = ctrl_r.pin_dir;

  // [R24] Interrupt request
  wire [2:0] irq_src = flag_r & irq_en_r;
  assign irq = |irq_src;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_r <= 10'h000;
    end else begin
      div_r <= div_r + 10'h001;
    end
  end

  // A count write blocks the match of the next tick
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      blk_r <= 1'b0;
    end else if (cnt_wr) begin
      blk_r <= 1'b1;
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r <= tmr_pkg::CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Direction resets to up so a fresh start climbs from BOTTOM
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      down_r <= 1'b0;
    end else begin
      down_r <= down_nxt;
    end
  end

  // Mode changes act at once; no glitch guard across a switch
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_r <= tmr_pkg::CTRL_RST;
    end else if (ctl_wr) begin
      ctrl_r <= tmr_pkg::tmr_ctrl_t'(pwdata[tmr_pkg::CTRL_W-1:0]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_en_r <= tmr_pkg::IRQEN_RST;
    end else if (ien_wr) begin
      irq_en_r <= pwdata[2:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_r <= tmr_pkg::FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= rd_mux;
    end
  end

endmodule

/* rtl/tmr_pkg.sv */
package tmr_pkg;

  // Register byte offsets on the APB window
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMPA  = 8'h08;
  localparam logic [7:0] ADDR_CMPB  = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_IRQEN = 8'h14;

  // Control word layout
  localparam int CTRL_W       = 12;
  localparam int FORCE_A_BIT  = 16;
  localparam int FORCE_B_BIT  = 17;

  // Flag bit positions
  localparam int FLAG_OVF     = 0;
  localparam int FLAG_CMPA    = 1;
  localparam int FLAG_CMPB    = 2;

  // Reset values and count limits
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [7:0] CMP_RST   = 8'h00;
  localparam logic [2:0] FLAG_RST  = 3'h0;
  localparam logic [2:0] IRQEN_RST = 3'h0;
  localparam logic [7:0] CNT_MAX   = 8'hFF;
  localparam logic [7:0] CNT_BOT   = 8'h00;

  // Prescaler masks: a tick when the masked divider bits are all one
  localparam logic [9:0] DIV_1    = 10'h000;
  localparam logic [9:0] DIV_8    = 10'h007;
  localparam logic [9:0] DIV_32   = 10'h01F;
  localparam logic [9:0] DIV_64   = 10'h03F;
  localparam logic [9:0] DIV_128  = 10'h07F;
  localparam logic [9:0] DIV_256  = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    TMR_NORMAL   = 3'b000,
    TMR_PC_FF    = 3'b001,
    TMR_CTC      = 3'b010,
    TMR_FAST_FF  = 3'b011,
    TMR_RES4     = 3'b100,
    TMR_PC_OCR   = 3'b101,
    TMR_RES6     = 3'b110,
    TMR_FAST_OCR = 3'b111
  } tmr_mode_t;

  typedef enum logic [1:0] {
    TMR_ACT_NONE   = 2'b00,
    TMR_ACT_TOGGLE = 2'b01,
    TMR_ACT_CLEAR  = 2'b10,
    TMR_ACT_SET    = 2'b11
  } tmr_act_t;

  // Bits [11:0] of the control register, msb first
  typedef struct packed {
    logic [1:0] pin_dir;
    tmr_act_t   act_b;
    tmr_act_t   act_a;
    logic [2:0] presc;
    tmr_mode_t  mode;
  } tmr_ctrl_t;

  localparam tmr_ctrl_t CTRL_RST = '0;

endpackage

/* test/tmr_pin_load.sv */
module tmr_pin_load (
  input  wire logic [1:0] cmp_out,
  input  wire logic [1:0] cmp_out_oe,
  output logic      [1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-down on each pin: a released pin reads low, never a stale level
  assign pin_lvl = cmp_out & cmp_out_oe;
endmodule

/* test/tmr_timer8_assertions.sv */
module tmr_timer8_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  cmp_out,
  input wire logic [1:0]  cmp_out_oe,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic               wr;
  logic [2:0]         ien_r;
  tmr_pkg::tmr_ctrl_t ctl_r;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of control and enables, rebuilt from bus writes
  assign wr = psel && penable && pwrite;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctl_r <= tmr_pkg::CTRL_RST;
      ien_r <= tmr_pkg::IRQEN_RST;
    end else begin
      if (wr && paddr == tmr_pkg::ADDR_CTRL)
        ctl_r <= tmr_pkg::tmr_ctrl_t'(pwdata[11:0]);
      if (wr && paddr == tmr_pkg::ADDR_IRQEN) ien_r <= pwdata[2:0];
    end
  end
  pin_enable_a:
    assert property (cmp_out_oe == ctl_r.pin_dir)
    else $error("pin enable differs from direction bits");
  stop_hold_a:
    assert property (ctl_r.presc == 3'h0 && !wr |=> $stable(cmp_out))
    else $error("compare output moved while stopped");
  idle_chan_a:
    assert property (ctl_r.act_a == tmr_pkg::TMR_ACT_NONE && !wr
      |=> $stable(cmp_out[0]))
    else $error("channel A output moved with no action");
  irq_gate_a:
    assert property (ien_r == 3'h0 |-> !irq)
    else $error("interrupt raised with all enables off");
  irq_fall_a:
    assert property ($fell(irq) |-> $past(wr) || !$past(rst_n))
    else $error("interrupt dropped without a bus write");
  err_scope_a:
    assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  unmapped_err_a:
    assert property (psel && penable && (paddr[1:0] != 2'h0
      || paddr > tmr_pkg::ADDR_IRQEN) |-> pslverr)
    else $error("unmapped access not refused");
  access_ready_a:
    assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule

bind tmr_timer8 tmr_timer8_chk u_chk (.ref_clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .cmp_out, .cmp_out_oe, .irq);

/* test/test_timer8_waveform_modes.sv */
module test_timer8_waveform_modes;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  cmp_out, cmp_out_oe, pin;
  int          miscompares, checks_done, seed, cyc, c, b, n, v, m;

  tmr_timer8 dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cmp_out, .cmp_out_oe, .irq);
  tmr_pin_load u_load (.cmp_out, .cmp_out_oe, .pin_lvl(pin));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    chk(32'(pslverr), 32'(err));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, e);
  endtask

  // Runs exactly t ticks at /1: start and stop writes are t edges apart
  task automatic run(input logic [31:0] ctl, input int t);
    wr(tmr_pkg::ADDR_CTRL, ctl | 32'h8);
    repeat (t - 3) @(posedge ref_clk);
    wr(tmr_pkg::ADDR_CTRL, ctl);
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] md,
    input logic [1:0] aa, ab, dir);
    return {20'h0, dir, ab, aa, 3'h0, md};
  endfunction

  function automatic int pc_cnt(input int t, tp);
    int p;
    p = t % (2 * tp);
    return (p <= tp) ? p : 2 * tp - p;
  endfunction

  function automatic logic pc_out(input int t, bp, tp, logic inv);
    return (t > 2 * tp - bp) ? !inv : (t > bp) && inv;
  endfunction

  function automatic int rnd(input int lim);
    return $unsigned($random(seed)) % lim;
  endfunction

  initial begin
    seed = 65220;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(8'(4 * i), 32'h0);
    apb(1'b1, 8'h18, 32'h7, 1'b1);
    apb(1'b0, 8'h06, 32'h0, 1'b1);
    chk(rd, 32'h0);
    // Compares sit one below the start so no match can fire
    for (int i = 0; i < 4; i++) begin
      v = (i == 3) ? 253 : rnd(256);
      n = 3 + rnd(4);
      wr(tmr_pkg::ADDR_COUNT, 32'(v));
      wr(tmr_pkg::ADDR_CMPA, 32'((v + 255) % 256));
      wr(tmr_pkg::ADDR_CMPB, 32'((v + 255) % 256));
      wr(tmr_pkg::ADDR_FLAGS, 32'h7);
      wr(tmr_pkg::ADDR_IRQEN, 32'h1);
      run(ctl(tmr_pkg::TMR_NORMAL, 2'h0, 2'h0, 2'h0), n);
      rdc(tmr_pkg::ADDR_COUNT, 32'((v + n) % 256));
      rdc(tmr_pkg::ADDR_FLAGS, 32'(v + n > 255));
      chk(32'(irq), 32'(v + n > 255));
    end
    wr(tmr_pkg::ADDR_FLAGS, 32'h7);
    rdc(tmr_pkg::ADDR_FLAGS, 32'h0);
    chk(32'(irq), 32'h0);
    do_reset();
    c = 2 + rnd(5);
    n = c + 1 + rnd(c + 1);
    wr(tmr_pkg::ADDR_CMPA, 32'(c));
    run(ctl(tmr_pkg::TMR_CTC, 2'h1, 2'h0, 2'h1), n);
    rdc(tmr_pkg::ADDR_COUNT, 32'(n % (c + 1)));
    chk(32'(pin), 32'h1);
    wr(tmr_pkg::ADDR_CTRL, ctl(tmr_pkg::TMR_CTC, 2'h1, 2'h0, 2'h0));
    rdc(tmr_pkg::ADDR_FLAGS, 32'h6);
    chk(32'(pin), 32'h0);
    wr(tmr_pkg::ADDR_FLAGS, 32'h7);
    wr(tmr_pkg::ADDR_COUNT, 32'hFE);
    run(ctl(tmr_pkg::TMR_CTC, 2'h0, 2'h0, 2'h0), 3);
    rdc(tmr_pkg::ADDR_COUNT, 32'h1);
    rdc(tmr_pkg::ADDR_FLAGS, 32'h5);
    for (int i = 0; i < 4; i++) begin
      do_reset();
      m = i[1] ? tmr_pkg::TMR_FAST_OCR : tmr_pkg::TMR_FAST_FF;
      c = 4 + rnd(8);
      n = 3 + rnd(c - 2);
      wr(tmr_pkg::ADDR_CMPA, 32'(c));
      wr(tmr_pkg::ADDR_COUNT, i[1] ? 32'(c - 1) : 32'hFE);
      run(ctl(3'(m), 2'(2 + i % 2), 2'h0, 2'h1), n);
      rdc(tmr_pkg::ADDR_COUNT, 32'(n - 2));
      rdc(tmr_pkg::ADDR_FLAGS, i[1] ? 32'h7 : 32'h5);
      chk(32'(pin), 32'(i % 2 == 0));
    end
    for (int i = 2; i < 4; i++) begin
      do_reset();
      c = 3 + rnd(6);
      b = 1 + rnd(c - 1);
      n = c + 1 + rnd(c + b);
      wr(tmr_pkg::ADDR_CMPA, 32'(c));
      wr(tmr_pkg::ADDR_CMPB, 32'(b));
      run(ctl(tmr_pkg::TMR_PC_OCR, 2'h0, 2'(i), 2'h2), n);
      rdc(tmr_pkg::ADDR_COUNT, 32'(pc_cnt(n, c)));
      rdc(tmr_pkg::ADDR_FLAGS, {29'h0, 2'h3, n > 2 * c});
      chk(32'(pin), {30'h0, pc_out(n, b, c, i == 3), 1'b0});
    end
    // Divide by 32 over 96 edges gives exactly three ticks
    do_reset();
    wr(tmr_pkg::ADDR_CTRL, 32'h18);
    repeat (93) @(posedge ref_clk);
    wr(tmr_pkg::ADDR_CTRL, 32'h0);
    rdc(tmr_pkg::ADDR_COUNT, 32'h3);
    do_reset();
    c = 2 + rnd(4);
    wr(tmr_pkg::ADDR_CMPA, 32'(c));
    run(ctl(tmr_pkg::TMR_FAST_FF, 2'h1, 2'h0, 2'h1), c + 1);
    rdc(tmr_pkg::ADDR_COUNT, 32'(c + 1));
    chk(32'(pin), 32'h1);
    do_reset();
    wr(tmr_pkg::ADDR_CMPA, 32'hFF);
    wr(tmr_pkg::ADDR_COUNT, 32'hFE);
    run(ctl(tmr_pkg::TMR_FAST_FF, 2'h2, 2'h0, 2'h1), 3);
    chk(32'(pin), 32'h1);
    close_out();
  end
endmodule
